// *** hw/kpl_core.sv ***
// Keypad layer priority stack with framed command handling
`timescale 1ns/1ps
module kpl_core
  import kpl_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [7:0] cfg_base_layer_in,
  input wire kpl_char_t cmd_char_in,
  input wire logic cmd_valid_in,
  input wire kpl_req_t req_in,
  input wire logic req_valid_in,
  input wire logic matrix_valid_in,
  input wire logic matrix_make_in,
  input wire logic [4:0] matrix_col_in,
  input wire logic [2:0] matrix_row_in,
  output logic [7:0] active_layer_out,
  output kpl_levels_t levels_out,
  output logic key_event_valid_out,
  output kpl_event_t key_event_out,
  output logic cmd_error_out
);
  // ****************************************
  // Command framing
  // ****************************************
  typedef enum logic [2:0] {KPL_P_IDLE, KPL_P_OP0, KPL_P_OP1, KPL_P_ARG, KPL_P_DONE} kpl_pstate_t;
  kpl_pstate_t pst_q, pst_d;
  logic [7:0] op0_q, op0_d;
  kpl_cmd_t pop_q, pop_d;
  logic [7:0] parg_q, parg_d;
  logic pexec;
  logic perr;

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= 8'h30) && (c <= 8'h39);
  endfunction

  function automatic kpl_cmd_t decode(input logic [7:0] a, input logic [7:0] b);
    kpl_cmd_t r;
    r = KPL_CMD_NONE;
    if (a == 8'h4b) begin
      case (b)
        8'h53: r = KPL_CMD_SELECT;
        8'h4c: r = KPL_CMD_LOCK;
        8'h44: r = KPL_CMD_DESELECT;
        8'h48: r = KPL_CMD_HOLD;
        8'h55: r = KPL_CMD_UNLOCK;
        8'h50: r = KPL_CMD_PRESS;
        8'h52: r = KPL_CMD_RELEASE;
        8'h42: r = KPL_CMD_BASE;
        default: r = KPL_CMD_NONE;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    pst_d = pst_q;
    op0_d = op0_q;
    pop_d = pop_q;
    parg_d = parg_q;
    pexec = 1'b0;
    perr = 1'b0;
    if (cmd_valid_in) begin
      if (cmd_char_in.data == KPL_CTRL_OPEN) begin
        pst_d = KPL_P_OP0;
        pop_d = KPL_CMD_NONE;
        parg_d = KPL_NO_LAYER;
      end else if (cmd_char_in.data == KPL_CTRL_CLOSE) begin
        pexec = (pst_q == KPL_P_ARG) && (pop_q != KPL_CMD_NONE);
        perr = (pst_q != KPL_P_IDLE) && !pexec;
        pst_d = KPL_P_IDLE;
      end else begin
        case (pst_q)
          KPL_P_IDLE: pst_d = KPL_P_IDLE;
          KPL_P_OP0: begin
            if (cmd_char_in.data != 8'h20) begin
              op0_d = cmd_char_in.data;
              pst_d = KPL_P_OP1;
            end
          end
          KPL_P_OP1: begin
            pop_d = decode(op0_q, cmd_char_in.data);
            pst_d = KPL_P_ARG;
          end
          KPL_P_ARG: begin
            if (is_digit(cmd_char_in.data)) begin
              parg_d = 8'((parg_q * 8'd10) + (cmd_char_in.data - 8'h30));
            end
          end
          default: pst_d = KPL_P_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pst_q <= KPL_P_IDLE;
      op0_q <= 8'h00;
      pop_q <= KPL_CMD_NONE;
      parg_q <= 8'h00;
    end else begin
      pst_q <= pst_d;
      op0_q <= op0_d;
      pop_q <= pop_d;
      parg_q <= parg_d;
    end
  end

  // ****************************************
  // Level stack and key events
  // ****************************************
  kpl_levels_t lev_q, lev_d;
  logic base_loaded_q, base_loaded_d;
  logic [7:0] make_layer_q [1:136];
  logic [7:0] make_layer_d [1:136];
  logic ev_v_q, ev_v_d;
  kpl_event_t ev_q, ev_d;
  logic err_q, err_d;
  kpl_cmd_t op;
  logic [7:0] arg;
  logic do_op;
  logic [7:0] mkey;
  logic [7:0] key;
  logic kmake;
  logic kvalid;
  logic [7:0] act;

  // Physical numbering; column 16 holds the eight special keys
  assign mkey = 8'({matrix_col_in, matrix_row_in} + 8'd1);

  always_comb begin
    // Parsed frames take precedence over a direct request in the same cycle
    do_op = pexec || req_valid_in;
    op = pexec ? pop_q : req_in.op;
    arg = pexec ? parg_q : req_in.arg;
  end

  function automatic logic [7:0] resolve(input kpl_levels_t l);
    if (l.hold != KPL_NO_LAYER) return l.hold;
    if (l.sel != KPL_NO_LAYER) return l.sel;
    if (l.lock != KPL_NO_LAYER) return l.lock;
    return l.base;
  endfunction

  assign act = resolve(lev_q);

  always_comb begin
    lev_d = lev_q;
    base_loaded_d = 1'b1;
    make_layer_d = make_layer_q;
    ev_v_d = 1'b0;
    ev_d = ev_q;
    err_d = perr;
    kvalid = 1'b0;
    kmake = 1'b0;
    key = 8'h00;
    if (!base_loaded_q) begin
      lev_d.base = cfg_base_layer_in;
    end
    if (do_op) begin
      case (op)
        KPL_CMD_SELECT: lev_d.sel = arg;
        KPL_CMD_LOCK: lev_d.lock = arg;
        KPL_CMD_DESELECT: lev_d.sel = KPL_NO_LAYER;
        KPL_CMD_HOLD: lev_d.hold = arg;
        KPL_CMD_UNLOCK: lev_d.lock = KPL_NO_LAYER;
        KPL_CMD_BASE: lev_d.base = arg;
        KPL_CMD_PRESS, KPL_CMD_RELEASE: begin
          kvalid = 1'b1;
          kmake = (op == KPL_CMD_PRESS);
          key = arg;
        end
        default: err_d = 1'b1;
      endcase
    end else if (matrix_valid_in) begin
      kvalid = 1'b1;
      kmake = matrix_make_in;
      key = mkey;
    end
    if (kvalid) begin
      if ((key < KPL_KEY_FIRST) || (key > KPL_KEY_LAST)) begin
        err_d = 1'b1;
      end else begin
        ev_v_d = 1'b1;
        ev_d.key = key;
        ev_d.make = kmake;
        if (kmake) begin
          ev_d.layer = act;
          make_layer_d[key] = act;
          // Hold ends here; the press still uses the held layer
          lev_d.hold = KPL_NO_LAYER;
        end else begin
          ev_d.layer = make_layer_q[key];
        end
      end
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      lev_q <= '0;
      base_loaded_q <= 1'b0;
      for (int i = 1; i <= 136; i++) begin
        make_layer_q[i] <= 8'h00;
      end
      ev_v_q <= 1'b0;
      ev_q <= '0;
      err_q <= 1'b0;
    end else begin
      lev_q <= lev_d;
      base_loaded_q <= base_loaded_d;
      make_layer_q <= make_layer_d;
      ev_v_q <= ev_v_d;
      ev_q <= ev_d;
      err_q <= err_d;
    end
  end

  assign active_layer_out = act;
  assign levels_out = lev_q;
  assign key_event_valid_out = ev_v_q;
  assign key_event_out = ev_q;
  assign cmd_error_out = err_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_hold_set;
    do_op && op == KPL_CMD_HOLD && arg != 8'h00 && !kvalid;
  endsequence

  a_hold_priority: assert property (@(posedge mclk_in) disable iff (reset_in)
    lev_q.hold != 8'h00 |-> active_layer_out == lev_q.hold) else $error("hold not active");
  a_select_write: assert property (@(posedge mclk_in) disable iff (reset_in)
    do_op && op == KPL_CMD_SELECT |=> levels_out.sel == $past(arg)) else $error("select not stored");
  a_deselect_zero: assert property (@(posedge mclk_in) disable iff (reset_in)
    do_op && op == KPL_CMD_DESELECT |=> levels_out.sel == 8'h00) else $error("deselect failed");
  a_hold_active: assert property (@(posedge mclk_in) disable iff (reset_in)
    s_hold_set |=> active_layer_out == $past(arg)) else $error("hold layer not active");
  a_hold_expire: assert property (@(posedge mclk_in) disable iff (reset_in)
    kvalid && kmake && ev_v_d |=> levels_out.hold == 8'h00 ##1 1'b1) else $error("hold not cleared");
  a_lock_masked: assert property (@(posedge mclk_in) disable iff (reset_in)
    do_op && op == KPL_CMD_LOCK && lev_q.sel != 8'h00 && lev_q.hold == 8'h00 && !kvalid
    |=> active_layer_out == $past(lev_q.sel)) else $error("lock overrode select");
  a_break_layer: assert property (@(posedge mclk_in) disable iff (reset_in)
    ev_v_q && !ev_q.make |-> ev_q.layer == make_layer_q[ev_q.key]) else $error("break layer wrong");
  a_frame_exec: assert property (@(posedge mclk_in) disable iff (reset_in)
    pexec |-> cmd_valid_in && cmd_char_in.data == KPL_CTRL_CLOSE) else $error("exec without close");
  a_lock_stays: assert property (@(posedge mclk_in) disable iff (reset_in)
    !(do_op && (op == KPL_CMD_LOCK || op == KPL_CMD_UNLOCK)) |=> $stable(levels_out.lock))
    else $error("lock changed");
endmodule

// *** hw/kpl_pkg.sv ***
// Package for the keypad layer priority block
package kpl_pkg;
  localparam int KPL_ID_W = 8;
  localparam int KPL_KEY_W = 8;
  localparam logic [7:0] KPL_NO_LAYER = 8'h00;
  localparam logic [7:0] KPL_KEY_FIRST = 8'h01;
  localparam logic [7:0] KPL_KEY_LAST = 8'h88;
  localparam logic [7:0] KPL_CTRL_OPEN = 8'h02;
  localparam logic [7:0] KPL_CTRL_CLOSE = 8'h03;
  localparam int KPL_ROWS = 8;

  typedef enum logic [3:0] {
    KPL_CMD_NONE,
    KPL_CMD_SELECT,
    KPL_CMD_LOCK,
    KPL_CMD_DESELECT,
    KPL_CMD_HOLD,
    KPL_CMD_UNLOCK,
    KPL_CMD_PRESS,
    KPL_CMD_RELEASE,
    KPL_CMD_BASE
  } kpl_cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic frame;
  } kpl_char_t;

  typedef struct packed {
    kpl_cmd_t op;
    logic [7:0] arg;
  } kpl_req_t;

  typedef struct packed {
    logic [7:0] hold;
    logic [7:0] sel;
    logic [7:0] lock;
    logic [7:0] base;
  } kpl_levels_t;

  typedef struct packed {
    logic [7:0] key;
    logic [7:0] layer;
    logic make;
  } kpl_event_t;
endpackage

// *** verif/kpl_src_model.sv ***
// Command source and keypad matrix model for the layer block
`timescale 1ns/1ps
module kpl_src_model
  import kpl_pkg::*;
(
  input wire logic mclk_in,
  output kpl_char_t cmd_char_out,
  output logic cmd_valid_out,
  output logic matrix_valid_out,
  output logic matrix_make_out,
  output logic [4:0] matrix_col_out,
  output logic [2:0] matrix_row_out
);
  initial begin
    cmd_char_out = '0;
    cmd_valid_out = 1'b0;
    matrix_valid_out = 1'b0;
    matrix_make_out = 1'b0;
    matrix_col_out = 5'h00;
    matrix_row_out = 3'h0;
  end
  task automatic put(input logic [7:0] c);
    @(posedge mclk_in);
    cmd_valid_out <= 1'b1;
    cmd_char_out <= '{data: c, frame: 1'b1};
  endtask
  // Framed text, one character a cycle, back to back
  task automatic cmd(input string s);
    put(KPL_CTRL_OPEN);
    for (int i = 0; i < s.len(); i++) begin
      put(s[i]);
    end
    put(KPL_CTRL_CLOSE);
    @(posedge mclk_in);
    cmd_valid_out <= 1'b0;
    // Released lines show the inverse so stale data cannot pass
    cmd_char_out.data <= ~KPL_CTRL_CLOSE;
  endtask
  task automatic key(input logic [4:0] col, input logic [2:0] row, input logic mk);
    @(posedge mclk_in);
    matrix_valid_out <= 1'b1;
    matrix_make_out <= mk;
    matrix_col_out <= col;
    matrix_row_out <= row;
    @(posedge mclk_in);
    matrix_valid_out <= 1'b0;
    matrix_col_out <= ~col;
    matrix_row_out <= ~row;
  endtask
endmodule

// *** verif/test_keypad_layer_priority.sv ***
// Self-checking testbench for the keypad layer priority block
`timescale 1ns/1ps
module test_keypad_layer_priority
  import kpl_pkg::*;
;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] cfg_base_layer_in = 8'h01;
  kpl_req_t req_in = '0;
  logic req_valid_in = 1'b0;
  kpl_char_t cmd_char_in;
  logic cmd_valid_in, matrix_valid_in, matrix_make_in;
  logic [4:0] matrix_col_in;
  logic [2:0] matrix_row_in;
  logic [7:0] active_layer_out;
  kpl_levels_t levels_out;
  logic key_event_valid_out, cmd_error_out;
  kpl_event_t key_event_out, ev_q;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int n_err = 0;
  int n0;
  always #2.5 mclk_in = ~mclk_in;
  kpl_src_model u_src (.mclk_in(mclk_in), .cmd_char_out(cmd_char_in), .cmd_valid_out(cmd_valid_in),
    .matrix_valid_out(matrix_valid_in), .matrix_make_out(matrix_make_in),
    .matrix_col_out(matrix_col_in), .matrix_row_out(matrix_row_in));
  kpl_core u_dut (.mclk_in(mclk_in), .reset_in(reset_in), .cfg_base_layer_in(cfg_base_layer_in),
    .cmd_char_in(cmd_char_in), .cmd_valid_in(cmd_valid_in), .req_in(req_in), .req_valid_in(req_valid_in),
    .matrix_valid_in(matrix_valid_in), .matrix_make_in(matrix_make_in), .matrix_col_in(matrix_col_in),
    .matrix_row_in(matrix_row_in), .active_layer_out(active_layer_out), .levels_out(levels_out),
    .key_event_valid_out(key_event_valid_out), .key_event_out(key_event_out), .cmd_error_out(cmd_error_out));
  // ****************
  // Monitor and timeout
  // ****************
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (key_event_valid_out === 1'b1) begin
      ev_q <= key_event_out;
    end
    if (cmd_error_out === 1'b1) begin
      n_err <= n_err + 1;
    end
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Levels, layer and event outputs stand until the next command, so a fixed settle is safe
  task automatic settle();
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  task automatic lv(input logic [7:0] h, s, l, b, a);
    chk("levels", 32'(levels_out), {h, s, l, b});
    chk("active", 32'(active_layer_out), 32'(a));
  endtask
  task automatic fr(input string s);
    u_src.cmd(s);
    settle();
  endtask
  task automatic ky(input logic [4:0] c, input logic [2:0] r, input logic mk);
    u_src.key(c, r, mk);
    settle();
  endtask
  task automatic req(input kpl_cmd_t op, input logic [7:0] a);
    @(posedge mclk_in);
    req_in <= '{op: op, arg: a};
    req_valid_in <= 1'b1;
    @(posedge mclk_in);
    req_valid_in <= 1'b0;
    settle();
  endtask
  task automatic rst();
    @(posedge mclk_in);
    reset_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    settle();
  endtask
  // ****************
  // Test sequence
  // ****************
  initial begin
    rst();
    lv(8'h00, 8'h00, 8'h00, 8'h01, 8'h01);
    $display("Test reset done");
    fr("KS 2");
    lv(8'h00, 8'h02, 8'h00, 8'h01, 8'h02);
    fr("KL 3");
    lv(8'h00, 8'h02, 8'h03, 8'h01, 8'h02);
    fr("KD");
    lv(8'h00, 8'h00, 8'h03, 8'h01, 8'h03);
    fr("KS 5");
    fr("KH 4");
    lv(8'h04, 8'h05, 8'h03, 8'h01, 8'h04);
    ky(5'h00, 3'h0, 1'b1);
    lv(8'h00, 8'h05, 8'h03, 8'h01, 8'h05);
    chk("press", 32'(ev_q), {15'h0, 8'h01, 8'h04, 1'b1});
    ky(5'h00, 3'h0, 1'b0);
    chk("break", 32'(ev_q), {15'h0, 8'h01, 8'h04, 1'b0});
    $display("Test hold done");
    req(KPL_CMD_DESELECT, 8'h00);
    lv(8'h00, 8'h00, 8'h03, 8'h01, 8'h03);
    fr("KL 2");
    lv(8'h00, 8'h00, 8'h02, 8'h01, 8'h02);
    fr("KL 1");
    lv(8'h00, 8'h00, 8'h01, 8'h01, 8'h01);
    fr("KU");
    lv(8'h00, 8'h00, 8'h00, 8'h01, 8'h01);
    req(KPL_CMD_BASE, 8'h07);
    lv(8'h00, 8'h00, 8'h00, 8'h07, 8'h07);
    $display("Test lock done");
    req(KPL_CMD_PRESS, 8'h81);
    chk("cmd press", 32'(ev_q), {15'h0, 8'h81, 8'h07, 1'b1});
    req(KPL_CMD_RELEASE, 8'h81);
    chk("cmd release", 32'(ev_q), {15'h0, 8'h81, 8'h07, 1'b0});
    fr("KP 136");
    chk("frame press", 32'(ev_q), {15'h0, 8'h88, 8'h07, 1'b1});
    ky(5'h10, 3'h7, 1'b0);
    chk("last key", 32'(ev_q), {15'h0, 8'h88, 8'h07, 1'b0});
    n0 = n_err;
    fr("KP 137");
    fr("KQ");
    chk("errors", 32'(n_err - n0), 32'h2);
    fr("KB 6");
    lv(8'h00, 8'h00, 8'h00, 8'h06, 8'h06);
    fr("KP 1");
    chk("frame make", 32'(ev_q), {15'h0, 8'h01, 8'h06, 1'b1});
    // Open mid-frame restarts parsing, the first command is dropped
    fr("KS 3\002KS 4");
    lv(8'h00, 8'h04, 8'h00, 8'h06, 8'h04);
    fr("KR 1");
    chk("frame break", 32'(ev_q), {15'h0, 8'h01, 8'h06, 1'b0});
    fr("KD");
    lv(8'h00, 8'h00, 8'h00, 8'h06, 8'h06);
    $display("Test keys done");
    fr("KH 9");
    @(posedge mclk_in);
    cfg_base_layer_in <= 8'h09;
    rst();
    lv(8'h00, 8'h00, 8'h00, 8'h09, 8'h09);
    $display("Test rereset done");
    summarize();
  end
endmodule
